// [src/wake_route_regs.sv]
// Overview of operation
// - all three registers reset to zero on power-up or software reset
// - eight wake enables, bit n for event n; enabled detected event raises wake request
// - configuration bit 2 set swaps keyboard and mouse clock/data inputs
// - configuration bits 1-0 choose visible extension bank 0 to 3
// - routing register reachable only with bank 2 selected, at index 13h
// - routing bits: ring one, ring two, keyboard, mouse, infrared, bit 6 software
// - routed detected event raises management interrupt regardless of wake enables
// - event status bits stick until software writes one; zero leaves them
`timescale 1ns/1ps
`default_nettype none

module wake_route_regs (
	input  wire logic                        sys_clk,
	input  wire logic                        srst,
	// ahb-lite slave
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	// detected events, one-cycle pulses from the detectors
	input  wire logic [7:0]                  gpEventDetect,
	input  wire logic [7:0]                  moduleEventDetect,
	// keyboard and mouse pins
	input  wire logic                        keyboardClockPin,
	input  wire logic                        keyboardDataPin,
	input  wire logic                        mouseClockPin,
	input  wire logic                        mouseDataPin,
	// inputs toward the keyboard controller
	output logic                             keyboardClockIn,
	output logic                             keyboardDataIn,
	output logic                             mouseClockIn,
	output logic                             mouseDataIn,
	// host-facing requests and configuration
	output logic                             powerWakeRequest,
	output logic                             mgmtInterrupt,
	output wake_route_pkg::bank_t            bankSelect,
	output logic                             powerButtonPulseS3En
);
	import wake_route_pkg::*;

	// ----------------------------------------------------------------
	// bus address phase capture
	// ----------------------------------------------------------------
	logic       wrPending_reg;
	logic       wrPending_next;
	logic [5:0] wrIndex_reg;
	logic [5:0] wrIndex_next;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;
	logic       addrPhase;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] gpWakeEnable_reg;
	logic [7:0] gpWakeEnable_next;
	logic [7:0] wakeConfig_reg;
	logic [7:0] wakeConfig_next;
	logic [7:0] mgmtRoute_reg;
	logic [7:0] mgmtRoute_next;
	logic [7:0] gpStatus;
	logic [7:0] gpStatusNext;
	logic [7:0] modStatus;
	logic [7:0] modStatusNext;
	logic [7:0] gpClear;
	logic [7:0] modClear;

	// ----------------------------------------------------------------
	// pin synchronisers and outputs
	// ----------------------------------------------------------------
	logic [3:0] pinMeta_reg;
	logic [3:0] pinSync_reg;
	logic [3:0] kbcIn_reg;
	logic [3:0] kbcIn_next;
	logic       wakeReq_reg;
	logic       wakeReq_next;
	logic       mgmtIrq_reg;
	logic       mgmtIrq_next;

	// true when the index is visible under the given bank
	function automatic logic idxVisible(input logic [5:0] idx, input logic [7:0] cfg);
		logic visible;
		visible = 1'b1;
		if (idx == IDX_MGMT_IRQ_ROUTE) begin
			visible = (bank_t'(cfg[CFG_BANK_MSB:CFG_BANK_LSB]) == BANK_ROUTING);
		end
		return visible;
	endfunction

	// read multiplexer over a set of register values
	function automatic logic [31:0] readMux(input logic [5:0] idx, input logic [7:0] modSt,
			input logic [7:0] gpSt, input logic [7:0] en, input logic [7:0] cfg,
			input logic [7:0] route);
		logic [7:0] value;
		value = 8'h00;
		case (idx)
			IDX_MOD_EVENT_STATUS: value = modSt;
			IDX_GP_EVENT_STATUS:  value = gpSt;
			IDX_GP_WAKE_ENABLE:   value = en;
			IDX_WAKE_CONFIG:      value = cfg;
			IDX_MGMT_IRQ_ROUTE:   value = idxVisible(idx, cfg) ? route : 8'h00;
			default:              value = 8'h00;
		endcase
		return {24'h00_0000, value};
	endfunction

	// ----------------------------------------------------------------
	// bus slave: zero wait states, always okay
	// ----------------------------------------------------------------
	assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdData_reg;

	// pending write and read data for the coming data phase
	always_comb begin
		wrPending_next = addrPhase & hwrite;
		wrIndex_next   = addrPhase ? haddr[7:2] : wrIndex_reg;
		rdData_next    = READ_ZERO;
		if (addrPhase & ~hwrite) begin
			rdData_next = readMux(haddr[7:2], modStatusNext, gpStatusNext,
				gpWakeEnable_next, wakeConfig_next, mgmtRoute_next);
		end
	end

	// register the bus phase state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wrPending_reg <= 1'b0;
			wrIndex_reg   <= 6'h00;
			rdData_reg    <= READ_ZERO;
		end else begin
			wrPending_reg <= wrPending_next;
			wrIndex_reg   <= wrIndex_next;
			rdData_reg    <= rdData_next;
		end
	end

	// ----------------------------------------------------------------
	// register writes in the data phase
	// ----------------------------------------------------------------
	always_comb begin
		gpWakeEnable_next = gpWakeEnable_reg;
		wakeConfig_next   = wakeConfig_reg;
		mgmtRoute_next    = mgmtRoute_reg;
		gpClear           = 8'h00;
		modClear          = 8'h00;
		if (wrPending_reg) begin
			case (wrIndex_reg)
				IDX_MOD_EVENT_STATUS: modClear = hwdata[7:0];
				IDX_GP_EVENT_STATUS:  gpClear = hwdata[7:0];
				IDX_GP_WAKE_ENABLE:   gpWakeEnable_next = hwdata[7:0];
				IDX_WAKE_CONFIG:      wakeConfig_next = hwdata[7:0] & CFG_WRITE_MASK;
				IDX_MGMT_IRQ_ROUTE: begin
					if (idxVisible(wrIndex_reg, wakeConfig_reg)) begin
						mgmtRoute_next = hwdata[7:0] & ROUTE_WRITE_MASK;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// register file, cleared by reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gpWakeEnable_reg <= RST_GP_WAKE_EN;
			wakeConfig_reg   <= RST_WAKE_CONFIG;
			mgmtRoute_reg    <= RST_MGMT_ROUTE;
		end else begin
			gpWakeEnable_reg <= gpWakeEnable_next;
			wakeConfig_reg   <= wakeConfig_next;
			mgmtRoute_reg    <= mgmtRoute_next;
		end
	end

	// ----------------------------------------------------------------
	// sticky detected-event flags
	// ----------------------------------------------------------------
	wake_event_status gpStatusBits (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.setPulse   (gpEventDetect),
		.clearMask  (gpClear),
		.status     (gpStatus),
		.statusNext (gpStatusNext)
	);

	wake_event_status modStatusBits (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.setPulse   (moduleEventDetect),
		.clearMask  (modClear),
		.status     (modStatus),
		.statusNext (modStatusNext)
	);

	// ----------------------------------------------------------------
	// request outputs
	// ----------------------------------------------------------------
	always_comb begin
		wakeReq_next = |(gpStatus & gpWakeEnable_reg);
		mgmtIrq_next = |(modStatus & mgmtRoute_reg & ROUTE_WRITE_MASK);
	end

	// ----------------------------------------------------------------
	// keyboard and mouse input exchange
	// ----------------------------------------------------------------
	always_comb begin
		if (wakeConfig_reg[CFG_SWAP_BIT]) begin
			kbcIn_next = {pinSync_reg[1:0], pinSync_reg[3:2]};
		end else begin
			kbcIn_next = pinSync_reg;
		end
	end

	// pin synchronisers, swap stage and request flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pinMeta_reg <= 4'hF;
			pinSync_reg <= 4'hF;
			kbcIn_reg   <= 4'hF;
			wakeReq_reg <= 1'b0;
			mgmtIrq_reg <= 1'b0;
		end else begin
			pinMeta_reg <= {keyboardClockPin, keyboardDataPin, mouseClockPin, mouseDataPin};
			pinSync_reg <= pinMeta_reg;
			kbcIn_reg   <= kbcIn_next;
			wakeReq_reg <= wakeReq_next;
			mgmtIrq_reg <= mgmtIrq_next;
		end
	end

	assign keyboardClockIn      = kbcIn_reg[3];
	assign keyboardDataIn       = kbcIn_reg[2];
	assign mouseClockIn         = kbcIn_reg[1];
	assign mouseDataIn          = kbcIn_reg[0];
	assign powerWakeRequest     = wakeReq_reg;
	assign mgmtInterrupt        = mgmtIrq_reg;
	assign bankSelect           = bank_t'(wakeConfig_reg[CFG_BANK_MSB:CFG_BANK_LSB]);
	assign powerButtonPulseS3En = wakeConfig_reg[CFG_PWR_PULSE_BIT];

endmodule // wake_route_regs

`default_nettype wire

// [src/wake_route_pkg.sv]
package wake_route_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_MOD_EVENT_STATUS = 6'h00;
	localparam logic [5:0] IDX_GP_EVENT_STATUS  = 6'h01;
	localparam logic [5:0] IDX_GP_WAKE_ENABLE   = 6'h03;
	localparam logic [5:0] IDX_WAKE_CONFIG      = 6'h04;
	localparam logic [5:0] IDX_MGMT_IRQ_ROUTE   = 6'h13;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
	localparam logic [7:0] RST_GP_WAKE_EN   = 8'h00;
	localparam logic [7:0] RST_WAKE_CONFIG  = 8'h00;
	localparam logic [7:0] RST_MGMT_ROUTE   = 8'h00;

	// ----------------------------------------------------------------
	// configuration register fields
	// ----------------------------------------------------------------
	localparam int         CFG_BANK_LSB     = 0;
	localparam int         CFG_BANK_MSB     = 1;
	localparam int         CFG_SWAP_BIT     = 2;
	localparam int         CFG_PWR_PULSE_BIT = 3;
	localparam logic [7:0] CFG_WRITE_MASK   = 8'h0F;

	// ----------------------------------------------------------------
	// routing register fields (bits 5 and 7 reserved)
	// ----------------------------------------------------------------
	localparam int         ROUTE_RING_ONE_BIT = 0;
	localparam int         ROUTE_RING_TWO_BIT = 1;
	localparam int         ROUTE_KEYBOARD_BIT = 2;
	localparam int         ROUTE_MOUSE_BIT    = 3;
	localparam int         ROUTE_INFRARED_BIT = 4;
	localparam int         ROUTE_SOFTWARE_BIT = 6;
	localparam logic [7:0] ROUTE_WRITE_MASK   = 8'h5F;

	// ----------------------------------------------------------------
	// bus encodings and banks
	// ----------------------------------------------------------------
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

	typedef enum logic [1:0] {
		BANK_KBD_MOUSE,
		BANK_INFRARED,
		BANK_ROUTING,
		BANK_STANDBY_GPIO
	} bank_t;

endpackage

// [src/wake_event_status.sv]
`timescale 1ns/1ps
`default_nettype none

module wake_event_status (
	input  wire logic                        sys_clk,
	input  wire logic                        srst,
	input  wire logic [7:0]                  setPulse,
	input  wire logic [7:0]                  clearMask,
	output logic      [7:0]                  status,
	output logic      [7:0]                  statusNext
);
	import wake_route_pkg::*;

	logic [7:0] status_reg;

	// sticky bits: write-one clears, a same-cycle event wins over the clear
	always_comb begin
		statusNext = (status_reg & ~clearMask) | setPulse;
	end

	// register the flags
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			status_reg <= RST_EVENT_STATUS;
		end else begin
			status_reg <= statusNext;
		end
	end

	assign status = status_reg;

endmodule // wake_event_status

`default_nettype wire

// [bench/host_request_sink.sv]
`timescale 1ns/1ps
`default_nettype none

module host_request_sink (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       powerWakeRequest,
	input  wire logic       mgmtInterrupt,
	output logic      [7:0] wakeCount,
	output logic      [7:0] mgmtCount
);
	logic wakeLast;
	logic mgmtLast;

	// the chipset counts each new request level it sees raised
	always_ff @(posedge sys_clk) begin
		wakeLast <= srst ? 1'b0 : powerWakeRequest;
		mgmtLast <= srst ? 1'b0 : mgmtInterrupt;
		if (srst) begin
			wakeCount <= 8'h00;
			mgmtCount <= 8'h00;
		end else begin
			if (powerWakeRequest && !wakeLast) wakeCount <= wakeCount + 8'h01;
			if (mgmtInterrupt && !mgmtLast) mgmtCount <= mgmtCount + 8'h01;
		end
	end
endmodule // host_request_sink

`default_nettype wire

// [bench/wake_route_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

module wake_route_regs_asserts (
	input wire logic                  sys_clk,
	input wire logic                  srst,
	input wire logic                  hsel,
	input wire logic [31:0]           haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic [31:0]           hwdata,
	input wire logic                  hready,
	input wire logic [31:0]           hrdata,
	input wire logic [7:0]            gpEventDetect,
	input wire logic [7:0]            moduleEventDetect,
	input wire logic                  keyboardClockPin,
	input wire logic                  mouseClockPin,
	input wire logic                  keyboardClockIn,
	input wire logic                  powerWakeRequest,
	input wire logic                  mgmtInterrupt,
	input wire wake_route_pkg::bank_t bankSelect
);
	import wake_route_pkg::*;
	logic       wp_reg, wp_next;
	logic [5:0] wi_reg, wi_next;
	logic [7:0] cfg_reg, cfg_next, en_reg, en_next, rt_reg, rt_next;
	logic [2:0] up_reg, up_next;

	// mirror of software writes, and cycles since reset left
	always_comb begin
		wp_next = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
		wi_next = haddr[7:2];
		cfg_next = cfg_reg;
		en_next = en_reg;
		rt_next = rt_reg;
		up_next = (up_reg == 3'h4) ? up_reg : up_reg + 3'h1;
		if (wp_reg && wi_reg == IDX_WAKE_CONFIG) cfg_next = hwdata[7:0] & CFG_WRITE_MASK;
		if (wp_reg && wi_reg == IDX_GP_WAKE_ENABLE) en_next = hwdata[7:0];
		if (wp_reg && wi_reg == IDX_MGMT_IRQ_ROUTE && cfg_reg[1:0] == 2'h2) begin
			rt_next = hwdata[7:0] & ROUTE_WRITE_MASK;
		end
		if (srst) begin
			cfg_next = 8'h00;
			en_next = 8'h00;
			rt_next = 8'h00;
			up_next = 3'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		wp_reg <= wp_next;
		wi_reg <= wi_next;
		cfg_reg <= cfg_next;
		en_reg <= en_next;
		rt_reg <= rt_next;
		up_reg <= up_next;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	reset_clear_a: assert property (disable iff (1'b0) srst |=>
		!powerWakeRequest && !mgmtInterrupt && hrdata == READ_ZERO && bankSelect == BANK_KBD_MOUSE)
		else $error("outputs not cleared by reset");
	wake_gate_a: assert property (up_reg != 3'h0 && $past(en_reg) == 8'h00 |-> !powerWakeRequest)
		else $error("wake request without enable");
	wake_raise_a: assert property (|(gpEventDetect & en_reg) |-> ##2 powerWakeRequest)
		else $error("enabled event gave no wake request");
	kbd_swap_a: assert property (up_reg >= 3'h3 |-> keyboardClockIn ==
		($past(cfg_reg[2]) ? $past(mouseClockPin, 3) : $past(keyboardClockPin, 3)))
		else $error("keyboard clock routed wrongly");
	bank_out_a: assert property (up_reg != 3'h0 |-> bankSelect == cfg_reg[1:0])
		else $error("bank select differs from config");
	cfg_read_a: assert property ($past(hsel && hready && htrans == HTRANS_NONSEQ &&
		!hwrite && haddr[7:2] == IDX_WAKE_CONFIG) |-> hrdata == {24'h00_0000, cfg_reg})
		else $error("config read back wrong");
	mgmt_gate_a: assert property (up_reg != 3'h0 && $past(rt_reg) == 8'h00 |-> !mgmtInterrupt)
		else $error("interrupt without routing");
	mgmt_raise_a: assert property (|(moduleEventDetect & rt_reg) |-> ##2 mgmtInterrupt)
		else $error("routed event gave no interrupt");

	cover property (powerWakeRequest);
	cover property (mgmtInterrupt);
	cover property (bankSelect == BANK_STANDBY_GPIO);
endmodule // wake_route_regs_asserts

bind wake_route_regs wake_route_regs_asserts i_wake_route_regs_asserts (.sys_clk(sys_clk),
	.srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .gpEventDetect(gpEventDetect),
	.moduleEventDetect(moduleEventDetect), .keyboardClockPin(keyboardClockPin),
	.mouseClockPin(mouseClockPin), .keyboardClockIn(keyboardClockIn),
	.powerWakeRequest(powerWakeRequest), .mgmtInterrupt(mgmtInterrupt), .bankSelect(bankSelect));

`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import wake_route_pkg::*;
	logic        sys_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
	logic [7:0]  gpEventDetect = 8'h00, moduleEventDetect = 8'h00, wakeCount, mgmtCount;
	logic        keyboardClockPin = 1'b1, keyboardDataPin = 1'b1;
	logic        mouseClockPin = 1'b1, mouseDataPin = 1'b1, hreadyout, hresp;
	logic        keyboardClockIn, keyboardDataIn, mouseClockIn, mouseDataIn;
	logic        powerWakeRequest, mgmtInterrupt, powerButtonPulseS3En;
	bank_t       bankSelect;
	int          errors = 0, compares = 0;

	wake_route_regs i_wake_route_regs (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .gpEventDetect,
		.moduleEventDetect, .keyboardClockPin, .keyboardDataPin, .mouseClockPin, .mouseDataPin,
		.keyboardClockIn, .keyboardDataIn, .mouseClockIn, .mouseDataIn, .powerWakeRequest,
		.mgmtInterrupt, .bankSelect, .powerButtonPulseS3En);
	host_request_sink i_host_request_sink (.sys_clk, .srst, .powerWakeRequest, .mgmtInterrupt,
		.wakeCount, .mgmtCount);

	always #2.5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// bus, event and compare helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rdChk(input logic [5:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0000_0000);
		check(rd, exp);
		check(32'(hresp), 32'h0000_0000);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// one-cycle detector pulses, then let the request flops land
	task automatic fire(input logic [7:0] gp, input logic [7:0] md);
		@(posedge sys_clk);
		gpEventDetect <= gp;
		moduleEventDetect <= md;
		@(posedge sys_clk);
		gpEventDetect <= 8'h00;
		moduleEventDetect <= 8'h00;
		settle(3);
	endtask

	task automatic conclude;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic runWake;
		rdChk(IDX_GP_WAKE_ENABLE, 32'(RST_GP_WAKE_EN));
		rdChk(IDX_WAKE_CONFIG, 32'(RST_WAKE_CONFIG));
		for (int n = 0; n < 8; n++) begin
			wr(IDX_GP_WAKE_ENABLE, 32'h0000_0001 << n);
			fire(8'h01 << n, 8'h00);
			check(32'(powerWakeRequest), 32'h0000_0001);
			wr(IDX_GP_EVENT_STATUS, 32'h0000_0001 << n);
			settle(2);
			check(32'(powerWakeRequest), 32'h0000_0000);
		end
		check(32'(wakeCount), 32'h0000_0008);
		fire(8'h01, 8'h00);
		check(32'(powerWakeRequest), 32'h0000_0000);
		wr(IDX_GP_EVENT_STATUS, 32'h0000_0000);
		rdChk(IDX_GP_EVENT_STATUS, 32'h0000_0001);
		wr(IDX_GP_EVENT_STATUS, 32'h0000_0001);
		rdChk(IDX_GP_EVENT_STATUS, 32'h0000_0000);
	endtask

	task automatic runBank;
		for (int b = 0; b < 4; b++) begin
			wr(IDX_WAKE_CONFIG, 32'(b));
			settle(2);
			check(32'(bankSelect), 32'(b));
			check(32'(powerButtonPulseS3En), 32'h0000_0000);
			rdChk(IDX_WAKE_CONFIG, 32'(b));
		end
		wr(IDX_WAKE_CONFIG, 32'h0000_0008);
		settle(2);
		check(32'(powerButtonPulseS3En), 32'h0000_0001);
		check(32'(bankSelect), 32'h0000_0000);
		rdChk(IDX_WAKE_CONFIG, 32'h0000_0008);
	endtask

	task automatic runRoute;
		int bits[6] = '{0, 1, 2, 3, 4, 6};
		rdChk(IDX_MGMT_IRQ_ROUTE, 32'(RST_MGMT_ROUTE));
		wr(IDX_WAKE_CONFIG, 32'h0000_0000);
		wr(IDX_MGMT_IRQ_ROUTE, 32'h0000_005F);
		rdChk(IDX_MGMT_IRQ_ROUTE, 32'h0000_0000);
		wr(IDX_WAKE_CONFIG, 32'h0000_0002);
		rdChk(IDX_MGMT_IRQ_ROUTE, 32'h0000_0000);
		wr(IDX_MGMT_IRQ_ROUTE, 32'h0000_005F);
		rdChk(IDX_MGMT_IRQ_ROUTE, 32'h0000_005F);
		wr(IDX_GP_WAKE_ENABLE, 32'h0000_0000);
		foreach (bits[i]) begin
			fire(8'h00, 8'h01 << bits[i]);
			check(32'(mgmtInterrupt), 32'h0000_0001);
			check(32'(powerWakeRequest), 32'h0000_0000);
			wr(IDX_MOD_EVENT_STATUS, 32'h0000_0001 << bits[i]);
			settle(2);
		end
		check(32'(mgmtCount), 32'h0000_0006);
		wr(IDX_MGMT_IRQ_ROUTE, 32'h0000_0004);
		fire(8'h00, 8'h08);
		check(32'(mgmtInterrupt), 32'h0000_0000);
	endtask

	task automatic runSwap;
		wr(IDX_WAKE_CONFIG, 32'h0000_0000);
		keyboardClockPin <= 1'b0;
		mouseDataPin <= 1'b0;
		settle(5);
		check({keyboardClockIn, keyboardDataIn, mouseClockIn, mouseDataIn}, 32'h0000_0006);
		wr(IDX_WAKE_CONFIG, 32'h0000_0004);
		settle(5);
		check({mouseClockIn, mouseDataIn, keyboardClockIn, keyboardDataIn}, 32'h0000_0006);
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		runWake;
		runBank;
		runRoute;
		runSwap;
		conclude;
	end

	// cut a hang short well past the expected run length
	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		conclude;
	end
endmodule // tb_top

`default_nettype wire
